// ### core/asc_ctrl.sv
// Serial port control, status and a FIFO-fed transmitter.
// Assumes a strobe register port and an outside receiver.
//
// Overview of operation
// - Port enable off stops prescaler, line driver
// - Transmitter runs only with its enable set
// - Receiver accepts characters only when enabled
// - Oversample select picks 16 or 8
// - Infrared mode forces 16x oversampling
// - Word length bit selects 8 or 9
// - Transmit empty raises interrupt when enabled
// - Transmit complete raises interrupt when enabled
// - Receive full or overrun interrupt enable
// - Frame, overrun, noise raise error interrupt
// - Parity fault raises interrupt when enabled
// - Transmit empty set once data shifted
// - Transmit complete set, write-one or data clears
// - Receive full cleared by read or one
// - Full receive register blocks new character
// - Transmit parity replaces most significant data bit
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module asc_ctrl
    import asc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic tx_line,
    output logic tx_line_oe,
    output logic sample_tick,
    output logic rx_hunt_on,
    input wire logic rx_char_valid,
    input wire logic [DATA_W-1:0] rx_char_data,
    input wire logic rx_parity_bit,
    input wire asc_err_s rx_char_err,
    output logic irq,
    output logic tx_dma_req,
    output logic rx_dma_req,
    output logic tx_fifo_ready
);
    asc_line_s line_ff;
    logic [6:0] irq_en_ff;
    logic infrared_on_ff;
    logic [15:0] baud_ff;
    logic [15:0] presc_ff;
    logic tx_done_ff;
    logic rx_full_ff;
    logic [DATA_W-1:0] rx_data_ff;
    asc_err_s err_ff;
    logic [31:0] reg_rdata_ff;
    asc_tx_state_e tx_state_ff;
    logic [DATA_W-1:0] tx_shift_ff;
    logic [3:0] bit_cnt_ff;
    logic [4:0] ovs_cnt_ff;
    logic tx_line_ff;
    logic tx_par_ff;
    logic bit_tick;
    logic ovs_eff;
    logic [4:0] ovs_len;
    logic [3:0] data_bits;
    logic tx_load;
    logic fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;
    logic wr_ctrl;
    logic wr_irq;
    logic wr_sts;
    logic wr_txd;
    logic wr_baud;
    logic wr_mode;
    logic wr_err;
    logic rd_rxd;
    logic rx_par_bad;
    logic rx_take;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    assign wr_ctrl = reg_wr && hit(reg_addr, LINE_FORMAT_CTRL_OFS);
    assign wr_irq = reg_wr && hit(reg_addr, IRQ_ENABLE_CTRL_OFS);
    assign wr_sts = reg_wr && hit(reg_addr, TRANSFER_STATUS_OFS);
    assign wr_txd = reg_wr && hit(reg_addr, TX_DATA_OFS);
    assign wr_baud = reg_wr && hit(reg_addr, BAUD_DIV_OFS);
    assign wr_mode = reg_wr && hit(reg_addr, MODE_CTRL_OFS);
    assign wr_err = reg_wr && hit(reg_addr, ERROR_FLAGS_OFS);
    assign rd_rxd = reg_rd && hit(reg_addr, RX_DATA_OFS);

    // Control registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_ff <= '0;
        end else if (wr_ctrl) begin
            line_ff.port_on <= reg_wdata[PORT_ON_BIT];
            line_ff.tx_side_on <= reg_wdata[TX_SIDE_ON_BIT];
            line_ff.rx_side_on <= reg_wdata[RX_SIDE_ON_BIT];
            line_ff.oversample_half_sel <= reg_wdata[OVERSAMPLE_HALF_SEL_BIT];
            line_ff.word_9 <= reg_wdata[WORD_9_BIT];
            line_ff.tx_dma_req_on <= reg_wdata[TX_DMA_REQ_ON_BIT];
            line_ff.rx_dma_req_on <= reg_wdata[RX_DMA_REQ_ON_BIT];
            line_ff.parity_on <= reg_wdata[PARITY_ON_BIT];
            line_ff.odd_parity_sel <= reg_wdata[ODD_PARITY_SEL_BIT];
            line_ff.two_stop <= reg_wdata[TWO_STOP_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_ff <= CTRL_RESET[6:0];
        end else if (wr_irq) begin
            irq_en_ff <= reg_wdata[6:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            infrared_on_ff <= 1'b0;
            baud_ff <= BAUD_RESET;
        end else begin
            if (wr_mode) begin
                infrared_on_ff <= reg_wdata[INFRARED_ON_BIT];
            end
            if (wr_baud) begin
                baud_ff <= reg_wdata[15:0];
            end
        end
    end

    // Infrared has no 8x sampling, so the select is overridden rather than rejected
    assign ovs_eff = line_ff.oversample_half_sel && !infrared_on_ff;
    assign ovs_len = ovs_eff ? OVS_8 : OVS_16;
    assign data_bits = line_ff.word_9 ? 4'h9 : 4'h8;

    // Prescaler held at zero while the port is off
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_ff <= 16'h0000;
        end else if (!line_ff.port_on) begin
            presc_ff <= 16'h0000;
        end else if (presc_ff + 16'h0001 >= baud_ff) begin
            presc_ff <= 16'h0000;
        end else begin
            presc_ff <= presc_ff + 16'h0001;
        end
    end
    assign sample_tick = line_ff.port_on && (presc_ff + 16'h0001 >= baud_ff);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovs_cnt_ff <= 5'h00;
        end else if (tx_state_ff == ASC_TX_IDLE) begin
            ovs_cnt_ff <= 5'h00;
        end else if (sample_tick) begin
            ovs_cnt_ff <= (ovs_cnt_ff + 5'h01 >= ovs_len) ? 5'h00 : ovs_cnt_ff + 5'h01;
        end
    end
    assign bit_tick = sample_tick && (ovs_cnt_ff + 5'h01 >= ovs_len);

    // Transmit FIFO: the shifter drains it, so a full FIFO back-pressures writers
    assign tx_load = (tx_state_ff == ASC_TX_IDLE) && fifo_out_valid && line_ff.port_on
        && line_ff.tx_side_on;

    asc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .flush(!line_ff.port_on),
        .in_valid(wr_txd),
        .in_ready(tx_fifo_ready),
        .in_data(reg_wdata[DATA_W-1:0]),
        .out_valid(fifo_out_valid),
        .out_ready(tx_load),
        .out_data(fifo_out_data)
    );

    // Transmit shifter
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_ff <= ASC_TX_IDLE;
            tx_shift_ff <= '0;
            bit_cnt_ff <= 4'h0;
            tx_line_ff <= 1'b1;
            tx_par_ff <= 1'b0;
        end else if (!line_ff.port_on || !line_ff.tx_side_on) begin
            tx_state_ff <= ASC_TX_IDLE;
            tx_line_ff <= 1'b1;
        end else begin
            case (tx_state_ff)
                ASC_TX_IDLE: begin
                    tx_line_ff <= 1'b1;
                    if (tx_load) begin
                        tx_shift_ff <= fifo_out_data;
                        tx_par_ff <= line_ff.odd_parity_sel;
                        bit_cnt_ff <= 4'h0;
                        tx_state_ff <= ASC_TX_START;
                        tx_line_ff <= 1'b0;
                    end
                end
                ASC_TX_START: begin
                    if (bit_tick) begin
                        tx_state_ff <= ASC_TX_DATA;
                        tx_line_ff <= tx_shift_ff[0];
                        tx_par_ff <= tx_par_ff ^ tx_shift_ff[0];
                        tx_shift_ff <= tx_shift_ff >> 1;
                        bit_cnt_ff <= 4'h1;
                    end
                end
                ASC_TX_DATA: begin
                    if (bit_tick) begin
                        if (bit_cnt_ff == data_bits) begin
                            tx_state_ff <= ASC_TX_STOP;
                            tx_line_ff <= 1'b1;
                            bit_cnt_ff <= line_ff.two_stop ? 4'h2 : 4'h1;
                        end else begin
                            // Last slot carries parity instead of the top data bit
                            if (line_ff.parity_on && bit_cnt_ff == data_bits - 4'h1) begin
                                tx_line_ff <= tx_par_ff;
                            end else begin
                                tx_line_ff <= tx_shift_ff[0];
                                tx_par_ff <= tx_par_ff ^ tx_shift_ff[0];
                            end
                            tx_shift_ff <= tx_shift_ff >> 1;
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end
                    end
                end
                ASC_TX_STOP: begin
                    if (bit_tick) begin
                        if (bit_cnt_ff == 4'h1) begin
                            tx_state_ff <= ASC_TX_IDLE;
                        end else begin
                            bit_cnt_ff <= bit_cnt_ff - 4'h1;
                        end
                    end
                end
                default: begin
                    tx_state_ff <= ASC_TX_IDLE;
                end
            endcase
        end
    end
    assign tx_line = tx_line_ff;
    assign tx_line_oe = line_ff.port_on;

    // Transmission complete: set wins over a write-one clear; a data write blocks the set
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_done_ff <= 1'b0;
        end else if (tx_state_ff == ASC_TX_STOP && bit_tick && bit_cnt_ff == 4'h1
            && !fifo_out_valid && !wr_txd) begin
            tx_done_ff <= 1'b1;
        end else if ((wr_sts && reg_wdata[TX_DONE_BIT]) || wr_txd) begin
            tx_done_ff <= 1'b0;
        end
    end

    // Receive holding register
    assign rx_hunt_on = line_ff.port_on && line_ff.rx_side_on;
    assign rx_take = rx_char_valid && rx_hunt_on;
    assign rx_par_bad = line_ff.parity_on
        && ((^rx_char_data[DATA_W-1:0]) ^ rx_parity_bit ^ line_ff.odd_parity_sel);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_full_ff <= 1'b0;
            rx_data_ff <= '0;
        end else if (rx_take && !rx_full_ff) begin
            rx_full_ff <= 1'b1;
            rx_data_ff <= line_ff.word_9 ? rx_char_data : {1'b0, rx_char_data[7:0]};
        end else if (rd_rxd || (wr_sts && reg_wdata[RX_FULL_BIT])) begin
            rx_full_ff <= 1'b0;
        end
    end

    // New error wins over a write-one clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_ff <= '0;
        end else begin
            err_ff.overrun_flag <= (rx_take && rx_full_ff)
                || (err_ff.overrun_flag && !(wr_err && reg_wdata[OVERRUN_FLAG_BIT]));
            err_ff.noise_flag <= (rx_take && !rx_full_ff && rx_char_err.noise_flag)
                || (err_ff.noise_flag && !(wr_err && reg_wdata[NOISE_FLAG_BIT]));
            err_ff.parity_fault <= (rx_take && !rx_full_ff && rx_par_bad)
                || (err_ff.parity_fault && !(wr_err && reg_wdata[PARITY_FAULT_BIT]));
            err_ff.frame_fault <= (rx_take && rx_char_err.frame_fault)
                || (err_ff.frame_fault && !(wr_err && reg_wdata[FRAME_FAULT_BIT]));
        end
    end

    // Requests are levels following the flags
    assign irq = (irq_en_ff[TX_EMPTY_IRQ_ON_BIT] && !fifo_out_valid)
        || (irq_en_ff[TX_DONE_IRQ_ON_BIT] && tx_done_ff)
        || (irq_en_ff[RX_FULL_IRQ_ON_BIT] && (rx_full_ff || err_ff.overrun_flag))
        || (irq_en_ff[ERROR_IRQ_ON_BIT] && (err_ff.frame_fault || err_ff.overrun_flag
            || err_ff.noise_flag))
        || (irq_en_ff[PARITY_IRQ_ON_BIT] && err_ff.parity_fault);
    assign tx_dma_req = line_ff.tx_dma_req_on && tx_fifo_ready && line_ff.tx_side_on;
    assign rx_dma_req = line_ff.rx_dma_req_on && rx_full_ff;

    // Data a cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_ff <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata_ff <= 32'h0000_0000;
            case (reg_addr)
                LINE_FORMAT_CTRL_OFS: begin
                    reg_rdata_ff[PORT_ON_BIT] <= line_ff.port_on;
                    reg_rdata_ff[TX_SIDE_ON_BIT] <= line_ff.tx_side_on;
                    reg_rdata_ff[RX_SIDE_ON_BIT] <= line_ff.rx_side_on;
                    reg_rdata_ff[OVERSAMPLE_HALF_SEL_BIT] <= ovs_eff;
                    reg_rdata_ff[WORD_9_BIT] <= line_ff.word_9;
                    reg_rdata_ff[TX_DMA_REQ_ON_BIT] <= line_ff.tx_dma_req_on;
                    reg_rdata_ff[RX_DMA_REQ_ON_BIT] <= line_ff.rx_dma_req_on;
                    reg_rdata_ff[PARITY_ON_BIT] <= line_ff.parity_on;
                    reg_rdata_ff[ODD_PARITY_SEL_BIT] <= line_ff.odd_parity_sel;
                    reg_rdata_ff[TWO_STOP_BIT] <= line_ff.two_stop;
                end
                IRQ_ENABLE_CTRL_OFS: begin
                    reg_rdata_ff[6:0] <= irq_en_ff & 7'h79;
                end
                TRANSFER_STATUS_OFS: begin
                    reg_rdata_ff[TX_EMPTY_BIT] <= !fifo_out_valid;
                    reg_rdata_ff[TX_DONE_BIT] <= tx_done_ff;
                    reg_rdata_ff[RX_FULL_BIT] <= rx_full_ff;
                end
                RX_DATA_OFS: begin
                    reg_rdata_ff[DATA_W-1:0] <= rx_data_ff;
                end
                BAUD_DIV_OFS: begin
                    reg_rdata_ff[15:0] <= baud_ff;
                end
                MODE_CTRL_OFS: begin
                    reg_rdata_ff[INFRARED_ON_BIT] <= infrared_on_ff;
                end
                ERROR_FLAGS_OFS: begin
                    reg_rdata_ff[OVERRUN_FLAG_BIT] <= err_ff.overrun_flag;
                    reg_rdata_ff[NOISE_FLAG_BIT] <= err_ff.noise_flag;
                    reg_rdata_ff[PARITY_FAULT_BIT] <= err_ff.parity_fault;
                    reg_rdata_ff[FRAME_FAULT_BIT] <= err_ff.frame_fault;
                end
                default: begin
                    reg_rdata_ff <= 32'h0000_0000;
                end
            endcase
        end
    end
    assign reg_rdata = reg_rdata_ff;
endmodule
`default_nettype wire

// ### core/asc_fifo.sv
// Synchronous FIFO, valid/ready on both sides.
// One clock; flip-flop storage by pointer.
`timescale 1ns/1ns
`default_nettype none
module asc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    assign in_ready = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data = mem_ff[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else if (flush) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + AW'(1);
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + AW'(1);
            end
            if (push && !pop) begin
                count_ff <= count_ff + (AW+1)'(1);
            end else if (pop && !push) begin
                count_ff <= count_ff - (AW+1)'(1);
            end
        end
    end
endmodule
`default_nettype wire

// ### core/asc_pkg.sv
// Package: register map, fields, resets and types of the serial port.
// Assumes one 50 MHz clock and a strobe register port.
package asc_pkg;
    localparam logic [7:0] LINE_FORMAT_CTRL_OFS = 8'h00;
    localparam logic [7:0] IRQ_ENABLE_CTRL_OFS = 8'h04;
    localparam logic [7:0] TRANSFER_STATUS_OFS = 8'h08;
    localparam logic [7:0] TX_DATA_OFS = 8'h0C;
    localparam logic [7:0] RX_DATA_OFS = 8'h10;
    localparam logic [7:0] BAUD_DIV_OFS = 8'h14;
    localparam logic [7:0] MODE_CTRL_OFS = 8'h18;
    localparam logic [7:0] ERROR_FLAGS_OFS = 8'h30;
    localparam int PORT_ON_BIT = 31;
    localparam int TX_SIDE_ON_BIT = 15;
    localparam int RX_SIDE_ON_BIT = 14;
    localparam int OVERSAMPLE_HALF_SEL_BIT = 13;
    localparam int WORD_9_BIT = 12;
    localparam int TX_DMA_REQ_ON_BIT = 11;
    localparam int RX_DMA_REQ_ON_BIT = 10;
    localparam int PARITY_ON_BIT = 2;
    localparam int ODD_PARITY_SEL_BIT = 1;
    localparam int TWO_STOP_BIT = 0;
    localparam int TX_EMPTY_IRQ_ON_BIT = 6;
    localparam int TX_DONE_IRQ_ON_BIT = 5;
    localparam int RX_FULL_IRQ_ON_BIT = 4;
    localparam int ERROR_IRQ_ON_BIT = 3;
    localparam int PARITY_IRQ_ON_BIT = 0;
    localparam int TX_EMPTY_BIT = 6;
    localparam int TX_DONE_BIT = 5;
    localparam int RX_FULL_BIT = 4;
    localparam int INFRARED_ON_BIT = 14;
    localparam int OVERRUN_FLAG_BIT = 7;
    localparam int NOISE_FLAG_BIT = 6;
    localparam int PARITY_FAULT_BIT = 5;
    localparam int FRAME_FAULT_BIT = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] BAUD_RESET = 16'h0010;
    localparam logic [4:0] OVS_16 = 5'h10;
    localparam logic [4:0] OVS_8 = 5'h08;
    localparam int DATA_W = 9;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [2:0] {
        ASC_TX_IDLE = 3'b000,
        ASC_TX_START = 3'b001,
        ASC_TX_DATA = 3'b011,
        ASC_TX_STOP = 3'b010
    } asc_tx_state_e;

    typedef struct packed {
        logic port_on;
        logic tx_side_on;
        logic rx_side_on;
        logic oversample_half_sel;
        logic word_9;
        logic tx_dma_req_on;
        logic rx_dma_req_on;
        logic parity_on;
        logic odd_parity_sel;
        logic two_stop;
    } asc_line_s;

    typedef struct packed {
        logic overrun_flag;
        logic noise_flag;
        logic parity_fault;
        logic frame_fault;
    } asc_err_s;
endpackage

// ### verification/asc_ctrl_asserts.sv
// Checker: port properties of the serial port control.
// Bound into asc_ctrl; one clock, async low reset.
`timescale 1ns/1ns
`default_nettype none
module asc_ctrl_asserts
    import asc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic tx_line,
    input wire logic tx_line_oe,
    input wire logic sample_tick,
    input wire logic rx_hunt_on,
    input wire logic rx_char_valid,
    input wire logic tx_dma_req,
    input wire logic rx_dma_req,
    input wire logic tx_fifo_ready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    port_off_idle_a: assert property (!tx_line_oe |=> tx_line) else $error("line not idle");
    prescaler_stop_a: assert property (!tx_line_oe |-> !sample_tick) else $error("tick while off");
    rx_hunt_gate_a: assert property (rx_hunt_on |-> tx_line_oe) else $error("rx on while off");
    enable_hold_a: assert property (!$past(reg_wr) |-> $stable(tx_line_oe) && $stable(rx_hunt_on))
        else $error("enable moved");
    tx_dma_room_a: assert property (tx_dma_req |-> tx_fifo_ready) else $error("tx req when full");
    rx_dma_rise_a: assert property ($rose(rx_dma_req) |-> $past(rx_char_valid) || $past(reg_wr))
        else $error("rx req unprompted");
    rx_dma_fall_a: assert property ($fell(rx_dma_req) |-> $past(reg_rd) || $past(reg_wr))
        else $error("rx full dropped");
    fifo_fill_a: assert property ($fell(tx_fifo_ready) |-> $past(reg_wr)) else $error("fill without write");
    rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata)) else $error("rdata moved");
endmodule
bind asc_ctrl asc_ctrl_asserts u_chk (.*);
`default_nettype wire

// ### verification/asc_far_node.sv
// Far node: decodes line frames and plays characters in.
// Bench gives bit length in clocks and data bits.
`timescale 1ns/1ns
`default_nettype none
module asc_far_node
    import asc_pkg::*;
(
    input wire logic core_clk,
    input wire logic tx_line,
    input wire logic tx_line_oe,
    input wire logic [7:0] bit_clks,
    input wire logic [3:0] nbits,
    output logic rx_char_valid,
    output logic [DATA_W-1:0] rx_char_data,
    output logic rx_parity_bit,
    output asc_err_s rx_char_err,
    output logic [DATA_W-1:0] got,
    output int gap,
    output int frames
);
    time t_last;
    initial begin
        rx_char_valid = 1'b0;
        rx_char_data = '0;
        rx_parity_bit = 1'b0;
        rx_char_err = '0;
        frames = 0;
        gap = 0;
        got = '0;
        t_last = 0;
        forever begin
            @(posedge core_clk);
            if (tx_line_oe && !tx_line) begin
                // Start edge spacing shows frame length, stop bits included
                gap = int'(($time - t_last) / 20);
                t_last = $time;
                got = '0;
                repeat (bit_clks / 2) @(posedge core_clk);
                for (int i = 0; i < nbits; i++) begin
                    repeat (bit_clks) @(posedge core_clk);
                    got[i] = tx_line;
                end
                repeat (bit_clks) @(posedge core_clk);
                frames++;
            end
        end
    end
    task automatic send(input logic [DATA_W-1:0] d, input logic p, input asc_err_s e);
        @(posedge core_clk);
        rx_char_valid <= 1'b1;
        rx_char_data <= d;
        rx_parity_bit <= p;
        rx_char_err <= e;
        @(posedge core_clk);
        rx_char_valid <= 1'b0;
        // Lines left by the receiver do not keep the last value
        rx_char_data <= ~d;
        rx_parity_bit <= ~p;
        rx_char_err <= ~e;
    endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Bench: register tests of the serial port control with a far node.
// Assumes 50 MHz; baud divider 1 keeps frames short.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import asc_pkg::*;
    logic core_clk, rst_n, reg_wr, reg_rd, tx_line, tx_line_oe, rx_char_valid, rx_parity_bit, irq;
    logic tx_dma_req, rx_dma_req, tx_fifo_ready, rx_hunt_on, p, sample_tick;
    logic [7:0] reg_addr, bit_clks;
    logic [3:0] nbits;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic [DATA_W-1:0] rx_char_data, got, ex;
    logic [4:0] cfgs [4] = '{5'h10, 5'h19, 5'h04, 5'h1F};
    asc_err_s rx_char_err;
    int gap, frames, base, nb, n;
    int fail_count = 0;
    int cmp_count = 0;
    asc_ctrl DUT (.*);
    asc_far_node far (.*);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(negedge core_clk);
    endtask
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(what, exp, reg_rdata & m);
    endtask
    task automatic wait_frames(input int k);
        for (int i = 0; i < 5000 && frames < k; i++) @(posedge core_clk);
        chk("frame count", k, frames);
    endtask
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        fail_count++;
        results();
    end
    initial begin
        rst_n = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata, bit_clks, nbits} = '0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd("ctrl rst", LINE_FORMAT_CTRL_OFS, '1, CTRL_RESET);
        rd("irq rst", IRQ_ENABLE_CTRL_OFS, '1, 0);
        rd("baud rst", BAUD_DIV_OFS, 32'hFFFF, 32'(BAUD_RESET));
        rd("txe rst", TRANSFER_STATUS_OFS, 32'h40, 32'h40);
        rd("unmapped", 8'h20, '1, 0);
        wr(LINE_FORMAT_CTRL_OFS, 32'h2000);
        rd("ovs sel", LINE_FORMAT_CTRL_OFS, 32'h2000, 32'h2000);
        wr(MODE_CTRL_OFS, 32'h4000);
        rd("ovs forced", LINE_FORMAT_CTRL_OFS, 32'h2000, 0);
        wr(MODE_CTRL_OFS, 32'h0);
        wr(BAUD_DIV_OFS, 32'h1);
        $display("test registers done");
        for (int c = 0; c < 4; c++) begin
            v = 32'h8000_8000;
            v[OVERSAMPLE_HALF_SEL_BIT] = cfgs[c][4];
            v[WORD_9_BIT] = cfgs[c][3];
            v[PARITY_ON_BIT] = cfgs[c][2];
            v[ODD_PARITY_SEL_BIT] = cfgs[c][1];
            v[TWO_STOP_BIT] = cfgs[c][0];
            nb = cfgs[c][3] ? 9 : 8;
            bit_clks = cfgs[c][4] ? 8'h08 : 8'h10;
            nbits = 4'(nb);
            ex = 9'h1A5 & 9'((1 << nb) - 1);
            p = cfgs[c][1];
            for (int i = 0; i < nb - 1; i++) p = p ^ ex[i];
            if (cfgs[c][2]) ex[nb-1] = p;
            wr(LINE_FORMAT_CTRL_OFS, v);
            base = frames;
            wr(TX_DATA_OFS, 32'h1A5);
            wr(TX_DATA_OFS, 32'h1A5);
            wait_frames(base + 2);
            chk("frame bits", 32'(ex), 32'(got));
            // One idle clock lies between back-to-back frames
            chk("frame len", (2 + nb + cfgs[c][0]) * bit_clks + 1, gap);
            repeat (3 * bit_clks) @(posedge core_clk);
            rd("tc set", TRANSFER_STATUS_OFS, 32'h20, 32'h20);
        end
        wr(TX_DATA_OFS, 32'h0F0);
        rd("tc data clr", TRANSFER_STATUS_OFS, 32'h20, 0);
        wait_frames(frames + 1);
        repeat (40) @(posedge core_clk);
        wr(IRQ_ENABLE_CTRL_OFS, 32'h20);
        chk("irq tc", 1, 32'(irq));
        wr(TRANSFER_STATUS_OFS, 32'h20);
        chk("irq tc clr", 0, 32'(irq));
        wr(IRQ_ENABLE_CTRL_OFS, 32'h40);
        chk("irq txe", 1, 32'(irq));
        wr(IRQ_ENABLE_CTRL_OFS, 32'h0);
        $display("test transmit done");
        // Transmitter held off so the buffer fills with no drain racing it
        nbits = 4'h8;
        wr(LINE_FORMAT_CTRL_OFS, 32'h8000_2800);
        n = 0;
        base = frames;
        for (int i = 0; i < 20 && tx_fifo_ready === 1'b1; i++) begin
            wr(TX_DATA_OFS, 32'(i));
            n++;
        end
        chk("depth", FIFO_DEPTH, n);
        chk("txdma full", 0, 32'(tx_dma_req));
        rd("txe clr", TRANSFER_STATUS_OFS, 32'h40, 0);
        chk("tx off", base, frames);
        wr(LINE_FORMAT_CTRL_OFS, 32'h8000_A800);
        wait_frames(base + FIFO_DEPTH);
        rd("txe again", TRANSFER_STATUS_OFS, 32'h40, 32'h40);
        chk("txdma room", 1, 32'(tx_dma_req));
        $display("test buffer done");
        wr(LINE_FORMAT_CTRL_OFS, 32'h8000_4400);
        chk("hunt", 1, 32'(rx_hunt_on));
        wr(IRQ_ENABLE_CTRL_OFS, 32'h10);
        far.send(9'h03C, 1'b0, '0);
        @(negedge core_clk);
        chk("rxdma", 1, 32'(rx_dma_req));
        chk("irq rxf", 1, 32'(irq));
        rd("rxf", TRANSFER_STATUS_OFS, 32'h10, 32'h10);
        far.send(9'h099, 1'b0, '0);
        rd("ovr", ERROR_FLAGS_OFS, 32'h80, 32'h80);
        rd("rx kept", RX_DATA_OFS, 32'h1FF, 32'h03C);
        rd("rxf rd clr", TRANSFER_STATUS_OFS, 32'h10, 0);
        chk("irq ovr", 1, 32'(irq));
        wr(IRQ_ENABLE_CTRL_OFS, 32'h0);
        chk("irq mask", 0, 32'(irq));
        wr(ERROR_FLAGS_OFS, 32'hFF);
        far.send(9'h00A, 1'b0, '{1'b0, 1'b1, 1'b0, 1'b1});
        rd("fe ne", ERROR_FLAGS_OFS, 32'hE8, 32'h48);
        wr(IRQ_ENABLE_CTRL_OFS, 32'h08);
        chk("irq err", 1, 32'(irq));
        wr(ERROR_FLAGS_OFS, 32'hFF);
        chk("irq err clr", 0, 32'(irq));
        wr(TRANSFER_STATUS_OFS, 32'h10);
        rd("rxf w1c", TRANSFER_STATUS_OFS, 32'h10, 0);
        wr(LINE_FORMAT_CTRL_OFS, 32'h8000_4404);
        far.send(9'h001, 1'b0, '0);
        rd("pe", ERROR_FLAGS_OFS, 32'h20, 32'h20);
        wr(IRQ_ENABLE_CTRL_OFS, 32'h01);
        chk("irq pe", 1, 32'(irq));
        $display("test receive done");
        results();
    end
endmodule
`default_nettype wire
